// ===== wdtc_pkg.sv
// Package for the watchdog timeout control block: register layout, reset values, timing.
// Assumes a single 25 MHz core clock and a 32.768 kHz tick strobe from the crystal domain.
package wdtc_pkg;
  // Control register bit positions
  localparam int unsigned WDTC_SEL_MSB = 7;
  localparam int unsigned WDTC_SEL_LSB = 4;
  localparam int unsigned WDTC_RESP_BIT = 3;
  localparam int unsigned WDTC_FLAG_BIT = 2;
  localparam int unsigned WDTC_RUN_BIT = 1;
  localparam int unsigned WDTC_UNLOCK_BIT = 0;
  localparam logic [7:0] WDTC_CTRL_RESET = 8'h00;
  // Select codes
  localparam logic [3:0] WDTC_SEL_MAX_PERIOD = 4'h7;
  localparam logic [3:0] WDTC_SEL_IMMEDIATE = 4'h8;
  // Base period is 512 ticks of the 32 kHz clock
  localparam int unsigned WDTC_BASE_TICKS_LOG2 = 9;
  localparam int unsigned WDTC_CNT_W = 17;
  localparam logic [WDTC_CNT_W-1:0] WDTC_CNT_ZERO = 17'h00000;
  localparam logic [WDTC_CNT_W-1:0] WDTC_CNT_ONE = 17'h00001;
  // Control register fields
  typedef struct packed {
    logic [3:0] timeout_select;
    logic timeout_response_select;
    logic timeout_occurred_flag;
    logic watchdog_run_refresh;
    logic control_write_unlock;
  } wdtc_ctrl_type;
  // Special function register access bundle
  typedef struct packed {
    logic wr;
    logic [7:0] wdata;
    logic instr_end;
  } wdtc_sfr_type;
endpackage

// ===== wdtc_period.sv
// Terminal count lookup for the watchdog prescale code.
// Uses only the low three bits of the code; the caller passes the full select and counts only for codes 0..7.
`timescale 1ns/1ps
`default_nettype none
module wdtc_period
  import wdtc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Code in, count out
  input wire logic [3:0] i_code,
  output logic [WDTC_CNT_W-1:0] o_limit
);
  logic [WDTC_CNT_W-1:0] limit_r;
  logic [WDTC_CNT_W-1:0] limit_nxt;
  always_comb begin
    // Registered so the shifter stays off the counter compare path
    limit_nxt = WDTC_CNT_ONE << (WDTC_BASE_TICKS_LOG2 + 32'(i_code[2:0])); // RQ8
  end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      limit_r <= WDTC_CNT_ZERO;
    end else begin
      limit_r <= limit_nxt;
    end
  end
  assign o_limit = limit_r;
endmodule
`default_nettype wire

// ===== wdtc_core.sv
// Watchdog timeout control: control register, 32 kHz tick counter, expiry response.
// Assumes the core flags the end of each instruction and drives the SFR write strobe.
// Summary of operation
// RQ1: Codes 4..7 give 250 ms to 2 s; code 8 resets at once; higher reserved.
// RQ2: Response bit set makes expiry interrupt; clear makes expiry reset the system.
// RQ3: Watchdog interrupt ignores the global interrupt mask.
// RQ4: Watchdog interrupt is always high priority, not programmable.
// RQ5: With interrupt response the watchdog repeats as a periodic timer.
// RQ6: Timeout status flag set on every timeout, either response.
// RQ7: Status flag cleared by external reset, kept through watchdog reset.
// RQ8: Period is two to the code times 512 ticks of the 32 kHz clock.
// RQ9: Writing run bit one starts and clears counter; must rewrite each period.
// RQ10: Control write accepted only right after the instruction setting unlock.
`timescale 1ns/1ps
`default_nettype none
module wdtc_core
  import wdtc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Ticks of the 32.768 kHz clock, one cycle each
  input wire logic i_tick_32k,
  // Special function register port
  input wire wdtc_sfr_type i_sfr,
  output logic [7:0] o_rdata,
  // Responses
  output logic o_wdog_reset,
  output logic o_wdog_irq,
  output logic o_wdog_irq_high_prio
);
  typedef enum logic [1:0] {
    WDTC_IDLE,
    WDTC_ARMED,
    WDTC_WINDOW
  } wdtc_unlock_type;
  typedef struct packed {
    wdtc_ctrl_type ctrl;
    wdtc_unlock_type unlock;
    logic [WDTC_CNT_W-1:0] count;
    logic reset_pulse;
    logic irq_pulse;
    logic limit_fresh;
  } wdtc_state_type;
  wdtc_state_type state_r;
  wdtc_state_type state_nxt;
  logic [WDTC_CNT_W-1:0] limit;
  logic write_ok;
  logic expire;
  wdtc_ctrl_type wctrl;
  logic unlock_req;
  logic refresh;
  logic sel_immediate;
  logic sel_counted;
  logic running;
  logic [WDTC_CNT_W-1:0] count_inc;
  logic count_step;
  logic count_hit;
  logic expire_irq;
  logic expire_reset;
  wdtc_period u_period (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_code(state_r.ctrl.timeout_select),
    .o_limit(limit)
  );
  // Decode of the register bus request
  always_comb begin
    wctrl = wdtc_ctrl_type'(i_sfr.wdata);
    unlock_req = i_sfr.wr && wctrl.control_write_unlock;
    // Write accepted only in the instruction right after the unlock one
    write_ok = i_sfr.wr && (state_r.unlock == WDTC_WINDOW); // RQ10
    refresh = write_ok && wctrl.watchdog_run_refresh; // RQ9
  end
  // Decode of the select code held in the register
  always_comb begin
    sel_immediate = (state_r.ctrl.timeout_select == WDTC_SEL_IMMEDIATE); // RQ1
    sel_counted = (state_r.ctrl.timeout_select <= WDTC_SEL_MAX_PERIOD); // RQ8
    // An accepted write preempts expiry, so a refresh never loses to a same-cycle timeout
    running = state_r.ctrl.watchdog_run_refresh && !write_ok;
  end
  // Tick counter and terminal count compare
  always_comb begin
    count_inc = state_r.count + WDTC_CNT_ONE;
    count_step = running && sel_counted && i_tick_32k;
    // The period register lags a select change by one cycle; compare held off meanwhile
    count_hit = state_r.limit_fresh && (count_inc >= limit); // RQ8
  end
  // Expiry and choice of response; reserved codes never fire
  always_comb begin
    expire = 1'b0;
    if (running && sel_immediate) begin
      expire = 1'b1; // RQ1
    end
    if (count_step && count_hit) begin
      expire = 1'b1; // RQ8
    end
    // Code 8 resets whatever the response bit says
    expire_irq = expire && state_r.ctrl.timeout_response_select && !sel_immediate; // RQ2
    expire_reset = expire && !expire_irq; // RQ2
  end
  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.reset_pulse = expire_reset; // RQ2
    state_nxt.irq_pulse = expire_irq; // RQ5
    unique case (state_r.unlock)
      WDTC_IDLE: begin
        if (unlock_req) begin
          state_nxt.unlock = WDTC_ARMED;
        end
      end
      WDTC_ARMED: begin
        if (i_sfr.instr_end) begin
          state_nxt.unlock = WDTC_WINDOW; // RQ10
        end
      end
      WDTC_WINDOW: begin
        // Any write or the next instruction end closes the window
        if (i_sfr.instr_end || i_sfr.wr) begin
          state_nxt.unlock = WDTC_IDLE; // RQ10
        end
      end
      default: begin
        state_nxt.unlock = WDTC_IDLE;
      end
    endcase
    if (write_ok) begin
      state_nxt.ctrl.timeout_select = wctrl.timeout_select;
      state_nxt.ctrl.timeout_response_select = wctrl.timeout_response_select;
      state_nxt.ctrl.watchdog_run_refresh = wctrl.watchdog_run_refresh;
      // Status is writable so software can clear it after reading the cause
      state_nxt.ctrl.timeout_occurred_flag = wctrl.timeout_occurred_flag;
    end
    if (refresh) begin
      state_nxt.count = WDTC_CNT_ZERO; // RQ9
    end else if (count_step && !count_hit) begin
      state_nxt.count = count_inc; // RQ8
    end
    if (expire) begin
      state_nxt.count = WDTC_CNT_ZERO; // RQ5
      state_nxt.ctrl.timeout_occurred_flag = 1'b1; // RQ6
      if (expire_reset) begin
        state_nxt.ctrl.watchdog_run_refresh = 1'b0; // RQ2
      end
    end
    // Period register follows the select one cycle late
    state_nxt.limit_fresh = (state_nxt.ctrl.timeout_select == state_r.ctrl.timeout_select);
    // Unlock bit is kept as a register copy of the unlock state, set while armed or in the window
    state_nxt.ctrl.control_write_unlock = (state_nxt.unlock != WDTC_IDLE); // RQ10
  end
  always_ff @(posedge i_clk) begin
    // Only the external reset pin reaches here; o_wdog_reset feeds the core, not this block
    if (!i_reset_n) begin
      state_r.ctrl <= wdtc_ctrl_type'(WDTC_CTRL_RESET); // RQ7
      state_r.unlock <= WDTC_IDLE;
      state_r.count <= WDTC_CNT_ZERO;
      state_r.reset_pulse <= 1'b0;
      state_r.irq_pulse <= 1'b0;
      state_r.limit_fresh <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end
  // Unlock bit reads back while the write window is open
  assign o_rdata = state_r.ctrl; // RQ10
  assign o_wdog_reset = state_r.reset_pulse;
  assign o_wdog_irq = state_r.irq_pulse; // RQ3
  assign o_wdog_irq_high_prio = 1'b1; // RQ4
endmodule
`default_nettype wire

// ===== wdtc_core_asserts.sv
// Port checker for the watchdog timeout control block.
// Assumes it is bound onto wdtc_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wdtc_core_asserts
  import wdtc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_tick_32k,
  input wire wdtc_sfr_type i_sfr,
  input wire logic [7:0] o_rdata,
  input wire logic o_wdog_reset,
  input wire logic o_wdog_irq,
  input wire logic o_wdog_irq_high_prio
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  a_prio_fixed: assert property (o_wdog_irq_high_prio) else $error("prio low");
  a_irq_flag: assert property (o_wdog_irq |-> o_rdata[2] && o_rdata[3]) else $error("irq");
  a_rst_flag: assert property (o_wdog_reset |-> o_rdata[2]) else $error("rst flag");
  a_rst_resp: assert property (o_wdog_reset && o_rdata[7:4] != 4'h8 |-> !o_rdata[3])
    else $error("rst resp");
  a_one_event: assert property (!(o_wdog_irq && o_wdog_reset)) else $error("both");
  a_irq_pulse: assert property (o_wdog_irq |=> !o_wdog_irq) else $error("irq long");
  a_imm_reset: assert property ($rose(o_rdata[7:4] == 4'h8) |-> ##[0:2] o_wdog_reset)
    else $error("no reset");
  // Only software or the external reset may clear the status
  a_flag_kept: assert property ($fell(o_rdata[2]) |-> $past(i_sfr.wr) || $past(i_sfr.wr, 2))
    else $error("flag lost");
  a_locked_wr: assert property (i_sfr.wr && !o_rdata[0] |=> $stable(o_rdata[7:3]))
    else $error("locked write");
endmodule
bind wdtc_core wdtc_core_asserts u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_tick_32k(i_tick_32k), .i_sfr(i_sfr), .o_rdata(o_rdata), .o_wdog_reset(o_wdog_reset),
  .o_wdog_irq(o_wdog_irq), .o_wdog_irq_high_prio(o_wdog_irq_high_prio));
`default_nettype wire

// ===== watchdog_timeout_control_tb.sv
// Testbench for the watchdog timeout control block.
// Assumes the tick input may be held high for one tick per clock.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timeout_control_tb;
  import wdtc_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_tick_32k = 1'b0;
  wdtc_sfr_type i_sfr = '0;
  logic [7:0] o_rdata;
  logic o_wdog_reset, o_wdog_irq, o_wdog_irq_high_prio;
  int n_mismatch = 0, num_checks = 0, n_irq = 0, n_rst = 0;
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    n_irq += int'(o_wdog_irq === 1'b1);
    n_rst += int'(o_wdog_reset === 1'b1);
  end
  wdtc_core uut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_tick_32k(i_tick_32k),
    .i_sfr(i_sfr), .o_rdata(o_rdata), .o_wdog_reset(o_wdog_reset), .o_wdog_irq(o_wdog_irq),
    .o_wdog_irq_high_prio(o_wdog_irq_high_prio));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Unlock, end of instruction, then the real write
  task automatic wr_ctrl(input logic [7:0] d);
    i_sfr <= '{1'b1, 8'h01, 1'b0};
    cyc(1);
    i_sfr <= '{1'b0, 8'h01, 1'b1};
    cyc(1);
    i_sfr <= '{1'b1, d, 1'b0};
    cyc(1);
    n_irq = 0;
    n_rst = 0;
    i_sfr <= '0;
    cyc(3);
  endtask
  task automatic tick(input int n);
    i_tick_32k <= 1'b1;
    cyc(n);
    i_tick_32k <= 1'b0;
    cyc(2);
  endtask
  task automatic period(input logic [3:0] c, input logic irq);
    int t;
    t = 2 ** (9 + c);
    wr_ctrl({c, irq, 3'b010});
    chk(o_rdata, {c, irq, 3'b010});
    tick(t - 1);
    chk(8'(n_irq + n_rst), 8'h00);
    tick(1);
    chk(8'(irq ? n_irq : n_rst), 8'h01);
    chk(o_rdata, {c, irq, 1'b1, irq, 1'b0});
    if (irq) begin
      tick(t);
      chk(8'(n_irq), 8'h02);
    end
  endtask
  task automatic t_basic();
    chk(o_rdata, 8'h00);
    chk({7'h00, o_wdog_irq_high_prio}, 8'h01);
    i_sfr <= '{1'b1, 8'h40, 1'b0};
    cyc(1);
    i_sfr <= '0;
    cyc(2);
    chk(o_rdata, 8'h00);
    i_sfr <= '{1'b1, 8'h01, 1'b0};
    cyc(1);
    chk(o_rdata, 8'h01);
    i_sfr <= '{1'b0, 8'h01, 1'b1};
    cyc(2);
    i_sfr <= '{1'b1, 8'h42, 1'b0};
    cyc(1);
    i_sfr <= '0;
    cyc(2);
    chk(o_rdata, 8'h00);
    $display("basic done");
  endtask
  task automatic t_timer();
    period(4'h0, 1'b1);
    period(4'h4, 1'b1);
    $display("timer done");
  endtask
  task automatic t_reset_resp();
    wr_ctrl(8'h12);
    tick(1000);
    wr_ctrl(8'h12);
    tick(1000);
    chk(8'(n_rst), 8'h00);
    period(4'h1, 1'b0);
    i_reset_n <= 1'b0;
    cyc(2);
    i_reset_n <= 1'b1;
    cyc(1);
    chk(o_rdata, 8'h00);
    $display("reset response done");
  endtask
  task automatic t_codes();
    wr_ctrl(8'h8a);
    chk(8'(n_rst != 0), 8'h01);
    chk(8'(n_irq), 8'h00);
    chk(o_rdata, 8'h8c);
    wr_ctrl(8'h9a);
    tick(1100);
    chk(8'(n_irq + n_rst), 8'h00);
    chk(o_rdata, 8'h9a);
    $display("codes done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    cyc(16);
    i_reset_n <= 1'b1;
    cyc(1);
    t_basic();
    t_timer();
    t_reset_resp();
    t_codes();
    results();
  end
  initial begin
    cyc(40000);
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
